/* File: inc/cts_pkg.sv */
// constants for the time stamp and buffer priority block
// assumes a protocol engine outside that flags frame events
package cts_pkg;
    localparam int BUF_COUNT = 32;
    localparam int ID_W = 29;
    localparam int MASK_COUNT = 4;
    localparam int STAMP_W = 16;
    localparam int BYTE_W = 8;
    localparam int DATA_BYTES = 8;
    localparam int LEN_W = 4;
    localparam int MSEL_W = 3;
    localparam int RANK_W = 3;
    // control bit positions
    localparam int CTRL_STAMP_POINT_BIT = 3;
    localparam int BUFCTRL_AUTO_STAMP_BIT = 5;
    // reset value and payload length limit
    localparam logic [STAMP_W-1:0] STAMP_RST = 16'h0000;
    localparam logic [LEN_W-1:0] LEN_MAX = 4'h8;
    // mask linkage codes per buffer
    localparam logic [MSEL_W-1:0] MSEL_NONE = 3'h0;
    localparam logic [MSEL_W-1:0] MSEL_MASK0 = 3'h1;
    // storage ranks, lower wins
    localparam logic [RANK_W-1:0] RANK_TX = 3'h1;
    localparam logic [RANK_W-1:0] RANK_UNMASKED = 3'h2;
    localparam logic [RANK_W-1:0] RANK_MASK0 = 3'h3;
    localparam logic [RANK_W-1:0] RANK_NONE = 3'h7;
    typedef enum logic {
        CTS_STAMP_AT_SOF,
        CTS_STAMP_AT_EOF
    } cts_stamp_mode_t;
endpackage

/* File: inc/cts_mem_if.sv */
// write and read port of the stamp store
// assumes both ends run on the one core clock
`timescale 1ns/1ps
interface cts_mem_if #(
    parameter int AW = 5,
    parameter int DW = 16
);
    logic wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
    modport mem (input wr_en, input wr_addr, input wr_data,
                 input rd_addr, output rd_data);
endinterface

/* File: verilog/cts_stamp_ram.sv */
// per-buffer stamp store with registered read data
// assumes one write and one read per cycle
`timescale 1ns/1ps
module cts_stamp_ram #(
    parameter int DEPTH = 32
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    cts_mem_if.mem port
);
    import cts_pkg::*;

    logic [STAMP_W-1:0] mem_q [DEPTH];
    logic [STAMP_W-1:0] rd_q;

    assign port.rd_data = rd_q;

    always_ff @(posedge core_clk_i) begin
        if (ce_i && port.wr_en) begin
            mem_q[port.wr_addr] <= port.wr_data;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_q <= STAMP_RST;
        end else if (ce_i) begin
            rd_q <= mem_q[port.rd_addr];
        end
    end
endmodule

/* File: verilog/cts_top.sv */
// time stamp capture, stamp insertion and buffer priority selection
// assumes frame events and buffer settings come from the protocol
// engine and the register file as plain synchronous levels and pulses
`timescale 1ns/1ps
module cts_top #(
    parameter int NBUF = cts_pkg::BUF_COUNT,
    parameter int NMASK = cts_pkg::MASK_COUNT
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic count_tick_i,
    input wire logic stamp_point_select_i,
    input wire logic tx_priority_select_i,
    input wire logic sof_i,
    input wire logic eof_valid_i,
    input wire logic rx_remote_i,
    input wire logic [cts_pkg::ID_W-1:0] rx_id_i,
    input wire logic [NBUF*cts_pkg::ID_W-1:0] buf_id_i,
    input wire logic [NBUF*cts_pkg::MSEL_W-1:0] buf_mask_sel_i,
    input wire logic [NBUF-1:0] buf_in_use_i,
    input wire logic [NBUF-1:0] buf_is_tx_i,
    input wire logic [NMASK*cts_pkg::ID_W-1:0] mask_id_bit_i,
    input wire logic [NBUF-1:0] new_data_clear_i,
    input wire logic [NBUF-1:0] tx_pending_flag_i,
    input wire logic tx_active_i,
    input wire logic auto_stamp_enable_i,
    input wire logic [cts_pkg::LEN_W-1:0] length_code_i,
    input wire logic [cts_pkg::DATA_BYTES*cts_pkg::BYTE_W-1:0] tx_data_i,
    input wire logic [$clog2(NBUF)-1:0] stamp_rd_addr_i,
    output logic [cts_pkg::STAMP_W-1:0] stamp_rd_data_o,
    output logic [cts_pkg::STAMP_W-1:0] counter_o,
    output logic [NBUF-1:0] new_data_flag_o,
    output logic rx_store_o,
    output logic [$clog2(NBUF)-1:0] rx_store_idx_o,
    output logic tx_sel_valid_o,
    output logic [$clog2(NBUF)-1:0] tx_sel_idx_o,
    output logic [cts_pkg::DATA_BYTES*cts_pkg::BYTE_W-1:0] tx_payload_o
);
    import cts_pkg::*;

    localparam int IW = $clog2(NBUF);
    localparam int RKEY_W = RANK_W + 1 + IW;
    localparam int TKEY_W = ID_W + IW;
    localparam int DW = DATA_BYTES * BYTE_W;

    generate
        if (NBUF < 2 || NBUF > BUF_COUNT) begin : g_bad_nbuf
            $error("NBUF must lie between 2 and 32");
        end
        if (NMASK < 1 || NMASK > MASK_COUNT) begin : g_bad_nmask
            $error("NMASK must lie between 1 and 4");
        end
        // every mask rank must stay below the no-match rank
        if (int'(RANK_MASK0) + NMASK - 1 >= int'(RANK_NONE)) begin : g_rank
            $error("mask ranks collide with the no-match rank");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // helpers

    // mask bit set means the bit is not compared
    function automatic logic id_hit(input logic [ID_W-1:0] a,
                                    input logic [ID_W-1:0] b,
                                    input logic [ID_W-1:0] m);
        id_hit = ((a ^ b) & ~m) == '0;
    endfunction

    // effective payload length, codes above eight act as eight
    function automatic logic [LEN_W-1:0] eff_len(input logic [LEN_W-1:0] c);
        eff_len = (c > LEN_MAX) ? LEN_MAX : c;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // counter and temporary capture

    logic [STAMP_W-1:0] counter_q;
    logic [STAMP_W-1:0] temp_q;
    cts_stamp_mode_t stamp_mode;
    logic [STAMP_W-1:0] store_stamp;

    assign stamp_mode = stamp_point_select_i ? CTS_STAMP_AT_EOF
                                             : CTS_STAMP_AT_SOF;
    assign store_stamp = (stamp_mode == CTS_STAMP_AT_EOF) ? counter_q
                                                           : temp_q;
    assign counter_o = counter_q;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            counter_q <= STAMP_RST;
        end else if (ce_i && count_tick_i) begin
            counter_q <= counter_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            temp_q <= STAMP_RST;
        end else if (ce_i && sof_i) begin
            temp_q <= counter_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive storage selection

    logic [NBUF-1:0] nd_q;
    logic [RKEY_W-1:0] rx_key [NBUF];

    genvar gi;

    // masks unpacked, slots without a mask compare every bit
    logic [ID_W-1:0] mask_arr [2**MSEL_W];
    generate
        for (gi = 0; gi < 2**MSEL_W; gi++) begin : g_mask
            if (gi < NMASK) begin : g_on
                assign mask_arr[gi] = mask_id_bit_i[gi*ID_W +: ID_W];
            end else begin : g_off
                assign mask_arr[gi] = '0;
            end
        end
    endgenerate

    generate
        for (gi = 0; gi < NBUF; gi++) begin : g_rx
            logic [ID_W-1:0] bid;
            logic [MSEL_W-1:0] msel;
            logic linked;
            logic [MSEL_W-1:0] mnum;
            logic [ID_W-1:0] mval;
            logic hit;
            logic [RANK_W-1:0] rank;
            assign bid = buf_id_i[gi*ID_W +: ID_W];
            assign msel = buf_mask_sel_i[gi*MSEL_W +: MSEL_W];
            // codes beyond the masks present count as unmasked
            assign linked = !buf_is_tx_i[gi] && msel != MSEL_NONE &&
                            msel <= MSEL_W'(NMASK);
            assign mnum = linked ? msel - MSEL_MASK0 : '0;
            // linked mask, all bits compared when unmasked
            assign mval = linked ? mask_arr[mnum] : '0;
            assign hit = buf_in_use_i[gi] && id_hit(rx_id_i, bid, mval) &&
                         (rx_remote_i || !buf_is_tx_i[gi]);
            // rank by buffer kind and linkage
            assign rank = !hit ? RANK_NONE :
                          buf_is_tx_i[gi] ? RANK_TX :
                          !linked ? RANK_UNMASKED :
                          RANK_W'(RANK_MASK0 + mnum);
            // new data then number break ties
            assign rx_key[gi] = {rank, nd_q[gi], IW'(gi)};
        end
    endgenerate

    logic [RKEY_W-1:0] rx_best;
    always_comb begin
        rx_best = rx_key[0];
        for (int i = 1; i < NBUF; i++) begin
            if (rx_key[i] < rx_best) begin
                rx_best = rx_key[i];
            end
        end
    end

    logic rx_found;
    logic [IW-1:0] rx_idx;
    logic do_store;
    assign rx_found = rx_best[RKEY_W-1 -: RANK_W] != RANK_NONE;
    assign rx_idx = rx_best[IW-1:0];
    assign do_store = eof_valid_i && rx_found;

    ////////////////////////////////////////////////////////////////////
    // stamp store

    cts_mem_if #(.AW(IW), .DW(STAMP_W)) mem_bus ();

    // write the winner's stamp on store
    assign mem_bus.wr_en = do_store;
    assign mem_bus.wr_addr = rx_idx;
    assign mem_bus.wr_data = store_stamp;
    assign mem_bus.rd_addr = stamp_rd_addr_i;
    assign stamp_rd_data_o = mem_bus.rd_data;

    cts_stamp_ram #(.DEPTH(NBUF)) u_ram (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .port(mem_bus.mem)
    );

    ////////////////////////////////////////////////////////////////////
    // new data flags, a store beats a clear in the same cycle

    logic [NBUF-1:0] nd_set;
    logic [NBUF-1:0] nd_d;
    assign nd_set = do_store ? (NBUF'(1) << rx_idx) : '0;
    assign nd_d = (nd_q & ~new_data_clear_i) | nd_set;
    assign new_data_flag_o = nd_q;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            nd_q <= '0;
            rx_store_o <= 1'b0;
            rx_store_idx_o <= '0;
        end else if (ce_i) begin
            nd_q <= nd_d;
            rx_store_o <= do_store;
            rx_store_idx_o <= do_store ? rx_idx : rx_store_idx_o;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit selection

    logic [TKEY_W-1:0] tx_key [NBUF];
    generate
        for (gi = 0; gi < NBUF; gi++) begin : g_tx
            assign tx_key[gi] = {tx_priority_select_i ? ID_W'(0)
                                 : buf_id_i[gi*ID_W +: ID_W], IW'(gi)};
        end
    endgenerate

    logic [TKEY_W-1:0] tx_best;
    logic tx_any;
    always_comb begin
        tx_best = '1;
        tx_any = 1'b0;
        for (int i = 0; i < NBUF; i++) begin
            if (tx_pending_flag_i[i] && buf_is_tx_i[i] &&
                (!tx_any || tx_key[i] < tx_best)) begin
                tx_best = tx_key[i];
                tx_any = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            tx_sel_valid_o <= 1'b0;
            tx_sel_idx_o <= '0;
        end else if (ce_i) begin
            tx_sel_valid_o <= tx_any;
            tx_sel_idx_o <= tx_any ? tx_best[IW-1:0] : '0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stamp insertion into the outgoing payload

    logic [LEN_W-1:0] tx_len;
    logic ins_on;
    logic [DW-1:0] payload_d;
    logic [DW-1:0] payload_q;
    assign tx_len = eff_len(length_code_i);
    // insertion needs the flag and two or more bytes
    assign ins_on = auto_stamp_enable_i && tx_len >= LEN_W'(2);

    // low byte then high byte at the tail
    always_comb begin
        payload_d = tx_data_i;
        if (ins_on) begin
            payload_d[(tx_len-LEN_W'(2))*BYTE_W +: BYTE_W] =
                counter_q[BYTE_W-1:0];
            payload_d[(tx_len-LEN_W'(1))*BYTE_W +: BYTE_W] =
                counter_q[STAMP_W-1 -: BYTE_W];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            payload_q <= '0;
        end else if (ce_i && sof_i && tx_active_i) begin
            payload_q <= payload_d;
        end
    end
    assign tx_payload_o = payload_q;
endmodule

/* File: tb/cts_sva.sv */
// assertions on the ports of the stamp and priority block
// assumes it is bound into the block's top module
`timescale 1ns/1ps
module cts_sva #(
    parameter int NBUF = 32
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic count_tick_i,
    input wire logic tx_priority_select_i,
    input wire logic sof_i,
    input wire logic eof_valid_i,
    input wire logic tx_active_i,
    input wire logic auto_stamp_enable_i,
    input wire logic [cts_pkg::LEN_W-1:0] length_code_i,
    input wire logic [63:0] tx_data_i,
    input wire logic [NBUF-1:0] buf_is_tx_i,
    input wire logic [NBUF-1:0] tx_pending_flag_i,
    input wire logic [15:0] counter_o,
    input wire logic [NBUF-1:0] new_data_flag_o,
    input wire logic rx_store_o,
    input wire logic [$clog2(NBUF)-1:0] rx_store_idx_o,
    input wire logic tx_sel_valid_o,
    input wire logic [$clog2(NBUF)-1:0] tx_sel_idx_o,
    input wire logic [63:0] tx_payload_o
);
    import cts_pkg::*;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (rst_i);
    wire logic [NBUF-1:0] pend = tx_pending_flag_i & buf_is_tx_i;
    function automatic int low_bit(input logic [NBUF-1:0] v);
        for (int i = NBUF - 1; i >= 0; i--)
            if (v[i])
                low_bit = i;
    endfunction
    function automatic logic [63:0] ins(input logic [63:0] d,
            input logic [3:0] n, input logic a, input logic [15:0] c);
        if (a && n >= 2)
            d[((n > 8 ? 8 : n) - 2) * 8 +: 16] = c;
        return d;
    endfunction
    sequence s_tx_sof;
        ce_i && sof_i && tx_active_i;
    endsequence
    property p_rst;
        $past(rst_i) |-> counter_o == 16'h0 && !rx_store_o && !tx_sel_valid_o;
    endproperty
    property p_step;
        ce_i && count_tick_i |=> counter_o == $past(counter_o) + 16'h1;
    endproperty
    property p_hold;
        ce_i && !count_tick_i |=> $stable(counter_o);
    endproperty
    property p_freeze;
        !ce_i |=> $stable(counter_o) && $stable(new_data_flag_o) &&
            $stable(tx_payload_o);
    endproperty
    property p_store;
        rx_store_o |-> $past(eof_valid_i && ce_i);
    endproperty
    property p_nd;
        rx_store_o |-> new_data_flag_o[rx_store_idx_o];
    endproperty
    property p_none;
        ce_i && pend == '0 |=> !tx_sel_valid_o;
    endproperty
    property p_num;
        ce_i && tx_priority_select_i && pend != '0 |=>
            tx_sel_valid_o && tx_sel_idx_o == low_bit($past(pend));
    endproperty
    property p_ins;
        s_tx_sof |=> tx_payload_o == ins($past(tx_data_i),
            $past(length_code_i), $past(auto_stamp_enable_i), $past(counter_o));
    endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    a_step: assert property (p_step) else $error("count step");
    a_hold: assert property (p_hold) else $error("count hold");
    a_freeze: assert property (p_freeze) else $error("enable freeze");
    a_store: assert property (p_store) else $error("store cause");
    a_nd: assert property (p_nd) else $error("new data flag");
    a_none: assert property (p_none) else $error("idle select");
    a_num: assert property (p_num) else $error("number order");
    a_ins: assert property (p_ins) else $error("stamp insert");
endmodule

/* File: tb/cts_peer.sv */
// far-side node: sends frames as start and valid-end events
// assumes the bench passes in its own image of the counter
`timescale 1ns/1ps
module cts_peer (
    input wire logic core_clk_i,
    input wire logic [15:0] cnt_i,
    output logic sof_o = 1'b0,
    output logic eof_o = 1'b0,
    output logic remote_o = 1'b0,
    output logic [cts_pkg::ID_W-1:0] id_o = '0
);
    import cts_pkg::*;
    // start pulse, five body cycles, end pulse, then id and remote inverted
    task automatic send(input logic [ID_W-1:0] id, input logic r,
            output logic [15:0] st);
        @(posedge core_clk_i);
        sof_o <= 1'b1;
        id_o <= id;
        remote_o <= r;
        @(negedge core_clk_i);
        st = cnt_i;
        @(posedge core_clk_i);
        sof_o <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        eof_o <= 1'b1;
        @(posedge core_clk_i);
        eof_o <= 1'b0;
        id_o <= ~id;
        remote_o <= ~r;
    endtask
endmodule

/* File: tb/test_cts_top.sv */
// bench for the stamp and priority block
// assumes the partner model makes every frame event
`timescale 1ns/1ps
module test_cts_top;
    import cts_pkg::*;
    typedef struct packed {logic [3:0] n; logic a; logic [3:0] p;} cts_row_t;
    localparam logic [ID_W-1:0] X = 29'h0000123;
    logic core_clk = 1'b0, rst = 1'b1, tick = 1'b1, mode = 1'b0, ce = 1'b1;
    logic prio = 1'b0, txa = 1'b0, auto = 1'b0, sof, eof, rem, stv, tsv;
    logic [3:0] len = 4'h0;
    logic [4:0] rda = 5'h00, sti, tsi;
    logic [15:0] ticks = 16'h0000, s0, rdd, cnt;
    logic [63:0] pay, data = 64'h8877665544332211;
    logic [ID_W-1:0] rid;
    logic [MASK_COUNT*ID_W-1:0] masks = '0;
    logic [BUF_COUNT*ID_W-1:0] ids = '0;
    logic [BUF_COUNT*MSEL_W-1:0] msel = '0;
    logic [BUF_COUNT-1:0] used = '0, istx = '0, ndc = '0, pend = '0, nd;
    int err_count = 0, n_compared = 0;
    cts_row_t rows [7] = '{'{4'h1, 1'b1, 4'hF}, '{4'h2, 1'b1, 4'h0},
        '{4'h3, 1'b1, 4'h1}, '{4'h8, 1'b1, 4'h6}, '{4'h9, 1'b1, 4'h6},
        '{4'hF, 1'b1, 4'h6}, '{4'h5, 1'b0, 4'hF}};
    cts_top u_dut (.core_clk_i(core_clk), .rst_i(rst), .ce_i(ce),
        .count_tick_i(tick), .stamp_point_select_i(mode),
        .tx_priority_select_i(prio), .sof_i(sof), .eof_valid_i(eof),
        .rx_remote_i(rem), .rx_id_i(rid), .buf_id_i(ids),
        .buf_mask_sel_i(msel), .buf_in_use_i(used), .buf_is_tx_i(istx),
        .mask_id_bit_i(masks), .new_data_clear_i(ndc),
        .tx_pending_flag_i(pend), .tx_active_i(txa),
        .auto_stamp_enable_i(auto), .length_code_i(len), .tx_data_i(data),
        .stamp_rd_addr_i(rda), .stamp_rd_data_o(rdd), .counter_o(cnt),
        .new_data_flag_o(nd), .rx_store_o(stv), .rx_store_idx_o(sti),
        .tx_sel_valid_o(tsv), .tx_sel_idx_o(tsi), .tx_payload_o(pay));
    cts_peer u_peer (.core_clk_i(core_clk), .cnt_i(ticks), .sof_o(sof),
        .eof_o(eof), .remote_o(rem), .id_o(rid));
    initial begin
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) ticks <= rst ? 16'h0 : ticks + {15'h0, tick & ce};
    task automatic check(string w, logic [127:0] s, logic [127:0] e);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic settle();
        @(posedge core_clk);
        @(negedge core_clk);
    endtask
    task automatic cfg(int n, logic [2:0] s, logic t, logic [ID_W-1:0] id);
        @(posedge core_clk);
        ids[n*ID_W +: ID_W] <= id;
        msel[n*MSEL_W +: MSEL_W] <= s;
        {used[n], istx[n]} <= {1'b1, t};
    endtask
    task automatic frame(logic [ID_W-1:0] id, logic r, logic [4:0] e);
        u_peer.send(id, r, s0);
        @(negedge core_clk);
        check("store", {stv, sti, nd[e]}, {1'b1, e, 1'b1});
        @(posedge core_clk);
        rda <= e;
        settle();
        check("stamp", rdd, mode ? s0 + 16'h6 : s0);
    endtask
    initial begin
        logic [63:0] ev;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check("reset", {cnt, nd, stv, tsv, pay}, '0);
        @(posedge core_clk);
        tick <= 1'b0;
        repeat (3) @(posedge core_clk);
        tick <= 1'b1;
        @(negedge core_clk);
        check("count", cnt, ticks);
        @(posedge core_clk);
        ce <= 1'b0;
        repeat (3) @(posedge core_clk);
        ce <= 1'b1;
        @(negedge core_clk);
        check("freeze", cnt, 16'h0002);
        foreach (rows[i]) begin
            @(posedge core_clk);
            {len, auto, txa} <= {rows[i].n, rows[i].a, 1'b1};
            u_peer.send(X, 1'b0, s0);
            ev = data;
            if (rows[i].p != 4'hF)
                ev[rows[i].p * 8 +: 16] = s0;
            @(negedge core_clk);
            check("payload", pay, ev);
        end
        @(posedge core_clk);
        {txa, masks[0]} <= 2'h1;
        cfg(3, MSEL_MASK0, 1'b0, X);
        cfg(7, MSEL_NONE, 1'b0, X);
        cfg(5, MSEL_NONE, 1'b0, X);
        cfg(9, MSEL_NONE, 1'b1, X);
        frame(X, 1'b0, 5'h05);
        frame(X, 1'b0, 5'h07);
        frame(X, 1'b0, 5'h05);
        frame(X, 1'b1, 5'h09);
        frame(X ^ 29'h0000001, 1'b0, 5'h03);
        @(posedge core_clk);
        {mode, ndc} <= {1'b1, 32'hFFFFFFFF};
        @(posedge core_clk);
        ndc <= '0;
        @(negedge core_clk);
        check("clear", nd, '0);
        frame(X, 1'b0, 5'h05);
        cfg(2, MSEL_NONE, 1'b1, 29'h0000200);
        cfg(4, MSEL_NONE, 1'b1, 29'h0000050);
        cfg(6, MSEL_NONE, 1'b1, 29'h0000050);
        @(posedge core_clk);
        pend <= 32'h00000254; // four pending
        settle();
        check("by id", {tsv, tsi}, 6'h24);
        @(posedge core_clk);
        prio <= 1'b1;
        settle();
        check("by number", {tsv, tsi}, 6'h22);
        @(posedge core_clk);
        pend <= '0;
        settle();
        check("none", {tsv, tsi}, '0);
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check("rerun", {cnt, nd, stv, tsv, pay}, '0);
        finish_test();
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        finish_test();
    end
endmodule
bind cts_top cts_sva #(.NBUF(NBUF)) u_sva (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .ce_i(ce_i), .count_tick_i(count_tick_i),
    .tx_priority_select_i(tx_priority_select_i), .sof_i(sof_i),
    .eof_valid_i(eof_valid_i), .tx_active_i(tx_active_i),
    .auto_stamp_enable_i(auto_stamp_enable_i),
    .length_code_i(length_code_i), .tx_data_i(tx_data_i),
    .buf_is_tx_i(buf_is_tx_i), .tx_pending_flag_i(tx_pending_flag_i),
    .counter_o(counter_o), .new_data_flag_o(new_data_flag_o),
    .rx_store_o(rx_store_o), .rx_store_idx_o(rx_store_idx_o),
    .tx_sel_valid_o(tx_sel_valid_o), .tx_sel_idx_o(tx_sel_idx_o),
    .tx_payload_o(tx_payload_o));
